/* afp_chk.sv */
// Checker: port-level properties of the audio FIFO port
`timescale 1ns/1ps
module afp_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [afp_pkg::AFP_DATA_W-1:0] dac_left,
    input wire logic [afp_pkg::AFP_DATA_W-1:0] dac_right,
    input wire logic sample_tick,
    input wire logic irq
);
    import afp_pkg::*;
    // ------
    // Helpers
    // ------
    logic [11:0] gap_q;
    logic seen_q;
    wire acc = psel && penable && pready && !pwrite;
    wire rd_ctrl = acc && paddr == AFP_CTRL_ADDR;
    wire rd_lvl = acc && paddr == AFP_LEVEL_ADDR;
    wire mapped = paddr == AFP_CTRL_ADDR || paddr == AFP_LEVEL_ADDR
        || paddr == AFP_LEFT_ADDR || paddr == AFP_RIGHT_ADDR;
    // First tick after reset has no reference, so period waits for it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_q <= 12'h0;
            seen_q <= 1'h0;
        end
        else
        begin
            gap_q <= sample_tick ? 12'h0 : gap_q + 12'h1;
            seen_q <= seen_q | sample_tick;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------
    // Properties
    // ------
    property p_rdy_first; psel && !penable ##1 psel && penable |-> pready;
    endproperty
    property p_rdy_once; pready |=> !pready; endproperty
    property p_err; pready |-> pslverr == !mapped; endproperty
    property p_ctrl_rsvd; rd_ctrl |-> prdata[31:10] == 22'h0
        && prdata[7:4] == 4'h0; endproperty
    property p_irq_read; rd_ctrl |-> (prdata[8] || prdata[9]) == $past(irq);
    endproperty
    property p_lvl_range; rd_lvl |-> prdata[7:0] <= 8'h80
        && prdata[15:8] <= 8'h80 && prdata[23:16] <= 8'h80
        && prdata[31:24] <= 8'h80; endproperty
    property p_tick_per; seen_q && sample_tick |-> gap_q == 12'h9c3;
    endproperty
    property p_dac_hold; $changed(dac_left) || $changed(dac_right)
        |-> sample_tick; endproperty
    a_rdy_first: assert property (p_rdy_first)
        else $error("ready late");
    a_rdy_once: assert property (p_rdy_once)
        else $error("ready held");
    a_err: assert property (p_err)
        else $error("error flag wrong");
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("reserved control bits set");
    a_irq_read: assert property (p_irq_read)
        else $error("irq differs from pending bits");
    a_lvl_range: assert property (p_lvl_range)
        else $error("level field above depth");
    a_tick_per: assert property (p_tick_per)
        else $error("sample period wrong");
    a_dac_hold: assert property (p_dac_hold)
        else $error("output word moved off tick");
    c_err: cover property (pslverr);
    c_pend: cover property (rd_ctrl && prdata[9]);
    c_full: cover property (rd_lvl && prdata[31:24] == 8'h0);
endmodule // afp_chk

bind afp_top afp_chk afp_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dac_left(dac_left), .dac_right(dac_right),
    .sample_tick(sample_tick), .irq(irq));

/* afp_codec.sv */
// Partner model: CODEC side offering one word pair per sample period
`timescale 1ns/1ps
module afp_codec
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_tick,
    output logic [afp_pkg::AFP_DATA_W-1:0] adc_left_in,
    output logic [afp_pkg::AFP_DATA_W-1:0] adc_right_in
);
    import afp_pkg::*;
    logic [15:0] n_q;
    // Fresh pair after each tick, held steady for the whole period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            n_q <= 16'h0;
        else if (sample_tick)
            n_q <= n_q + 16'h1;
    end
    assign adc_left_in = {16'h0a0a, n_q};
    assign adc_right_in = {16'h0b0b, n_q};
endmodule // afp_codec

/* afp_fifo.sv */
// Module: one 128 x 32 sample queue with flush, built from flip-flops
`timescale 1ns/1ps
module afp_fifo
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic push,
    input wire logic [afp_pkg::AFP_DATA_W-1:0] push_data,
    input wire logic pop,
    output logic [afp_pkg::AFP_DATA_W-1:0] head_data,
    output logic [afp_pkg::AFP_CNT_W-1:0] count,
    output logic full,
    output logic empty
);
    import afp_pkg::*;

    logic [AFP_DATA_W-1:0] mem_q [AFP_DEPTH];
    logic [AFP_PTR_W-1:0] wr_q;
    logic [AFP_PTR_W-1:0] rd_q;
    logic [AFP_CNT_W-1:0] cnt_q;
    wire do_push;
    wire do_pop;

    // Full pushes and empty pops are dropped so the queue never corrupts
    assign do_push = push && !full && !flush;
    assign do_pop = pop && !empty && !flush;
    assign full = (cnt_q == AFP_DEPTH_CNT);
    assign empty = (cnt_q == '0);
    assign count = cnt_q;
    assign head_data = mem_q[rd_q];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (flush)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (do_push)
                wr_q <= wr_q + 7'h01;
            if (do_pop)
                rd_q <= rd_q + 7'h01;
            if (do_push && !do_pop)
                cnt_q <= cnt_q + 8'h01;
            else if (do_pop && !do_push)
                cnt_q <= cnt_q - 8'h01;
        end
    end

    // Storage has no reset; contents are meaningless until written
    always_ff @(posedge pclk)
    begin
        if (do_push)
            mem_q[wr_q] <= push_data;
    end

endmodule // afp_fifo

/* afp_pkg.sv */
// Package: audio FIFO port register map, fields and timing constants
package afp_pkg;

    // ------------------------------------------------------------
    // Bus and storage geometry
    // ------------------------------------------------------------
    localparam int AFP_DATA_W = 32;
    localparam int AFP_DEPTH = 128;
    localparam int AFP_PTR_W = 7;
    localparam int AFP_CNT_W = 8;
    localparam logic [AFP_CNT_W-1:0] AFP_DEPTH_CNT = 8'h80;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] AFP_CTRL_ADDR = 32'hff203040;
    localparam logic [31:0] AFP_LEVEL_ADDR = 32'hff203044;
    localparam logic [31:0] AFP_LEFT_ADDR = 32'hff203048;
    localparam logic [31:0] AFP_RIGHT_ADDR = 32'hff20304c;

    // ------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------
    localparam int AFP_IN_IRQ_EN_BIT = 0;
    localparam int AFP_OUT_IRQ_EN_BIT = 1;
    localparam int AFP_FLUSH_IN_BIT = 2;
    localparam int AFP_FLUSH_OUT_BIT = 3;
    localparam int AFP_IN_IRQ_PEND_BIT = 8;
    localparam int AFP_OUT_IRQ_PEND_BIT = 9;
    localparam logic [3:0] AFP_CTRL_RESET = 4'h0;

    // Level register field positions (low bit of each byte)
    localparam int AFP_RIGHT_IN_POS = 0;
    localparam int AFP_LEFT_IN_POS = 8;
    localparam int AFP_RIGHT_OUT_POS = 16;
    localparam int AFP_LEFT_OUT_POS = 24;

    // ------------------------------------------------------------
    // Thresholds: 75 % and 25 % of 128 words
    // ------------------------------------------------------------
    localparam logic [AFP_CNT_W-1:0] AFP_HIGH_MARK = 8'h60;
    localparam logic [AFP_CNT_W-1:0] AFP_LOW_MARK = 8'h20;

    // ------------------------------------------------------------
    // Timing: 20 MHz clock, 8000 sample pairs per second
    // ------------------------------------------------------------
    localparam int AFP_CLK_HZ = 20000000;
    localparam int AFP_SAMPLE_HZ = 8000;
    localparam int AFP_SAMPLE_CYCLES = AFP_CLK_HZ / AFP_SAMPLE_HZ;
    localparam int AFP_TICK_W = 12;
    localparam logic [AFP_TICK_W-1:0] AFP_TICK_LAST =
        AFP_TICK_W'(AFP_SAMPLE_CYCLES - 1);

endpackage

/* afp_top.sv */
// Module: audio FIFO port with APB register slave and sample pacing
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module afp_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [afp_pkg::AFP_DATA_W-1:0] adc_left_in,
    input wire logic [afp_pkg::AFP_DATA_W-1:0] adc_right_in,
    output logic [afp_pkg::AFP_DATA_W-1:0] dac_left,
    output logic [afp_pkg::AFP_DATA_W-1:0] dac_right,
    output logic sample_tick,
    output logic irq
);
    import afp_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // A full queue reports no free words, an empty one the whole depth
    function automatic logic [AFP_CNT_W-1:0] free_words(
        input logic [AFP_CNT_W-1:0] held
    );
        free_words = AFP_DEPTH_CNT - held;
    endfunction

    function automatic logic [31:0] ctrl_word(
        input logic [3:0] ctrl,
        input logic in_pend,
        input logic out_pend
    );
        logic [31:0] w;
        w = '0;
        w[AFP_IN_IRQ_EN_BIT] = ctrl[AFP_IN_IRQ_EN_BIT];
        w[AFP_OUT_IRQ_EN_BIT] = ctrl[AFP_OUT_IRQ_EN_BIT];
        w[AFP_FLUSH_IN_BIT] = ctrl[AFP_FLUSH_IN_BIT];
        w[AFP_FLUSH_OUT_BIT] = ctrl[AFP_FLUSH_OUT_BIT];
        w[AFP_IN_IRQ_PEND_BIT] = in_pend;
        w[AFP_OUT_IRQ_PEND_BIT] = out_pend;
        ctrl_word = w;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0] ctrl_q;
    logic in_pend_q;
    logic out_pend_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [AFP_TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    logic [AFP_DATA_W-1:0] dac_left_q;
    logic [AFP_DATA_W-1:0] dac_right_q;
    logic irq_q;

    wire incoming_irq_enable;
    wire outgoing_irq_enable;
    wire flush_inbound;
    wire flush_outbound;
    wire setup;
    wire access_done;
    wire hit_ctrl;
    wire hit_level;
    wire hit_left;
    wire hit_right;
    wire hit_any;
    wire wr_ctrl;
    wire rd_left;
    wire rd_right;
    wire wr_left;
    wire wr_right;
    wire tick_now;
    wire in_hot;
    wire out_cold;
    wire out_warm;
    wire in_pend_d;
    wire out_pend_d;
    wire [31:0] level_word;
    wire [31:0] read_mux;

    wire [AFP_DATA_W-1:0] lin_head;
    wire [AFP_DATA_W-1:0] rin_head;
    wire [AFP_DATA_W-1:0] lout_head;
    wire [AFP_DATA_W-1:0] rout_head;
    wire [AFP_CNT_W-1:0] left_in_count;
    wire [AFP_CNT_W-1:0] right_in_count;
    wire [AFP_CNT_W-1:0] lout_cnt;
    wire [AFP_CNT_W-1:0] rout_cnt;
    wire [AFP_CNT_W-1:0] left_out_space;
    wire [AFP_CNT_W-1:0] right_out_space;
    wire lout_empty;
    wire rout_empty;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    assign incoming_irq_enable = ctrl_q[AFP_IN_IRQ_EN_BIT];
    assign outgoing_irq_enable = ctrl_q[AFP_OUT_IRQ_EN_BIT];
    assign flush_inbound = ctrl_q[AFP_FLUSH_IN_BIT];
    assign flush_outbound = ctrl_q[AFP_FLUSH_OUT_BIT];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready_q;
    // Full 32-bit compare, so no alias can reach the flush bits
    assign hit_ctrl = (paddr == AFP_CTRL_ADDR);
    assign hit_level = (paddr == AFP_LEVEL_ADDR);
    assign hit_left = (paddr == AFP_LEFT_ADDR);
    assign hit_right = (paddr == AFP_RIGHT_ADDR);
    assign hit_any = hit_ctrl || hit_level || hit_left || hit_right;
    assign wr_ctrl = access_done && pwrite && hit_ctrl;
    // Level register has no write effect; writes to it are ignored
    assign rd_left = access_done && !pwrite && hit_left;
    assign rd_right = access_done && !pwrite && hit_right;
    assign wr_left = access_done && pwrite && hit_left;
    assign wr_right = access_done && pwrite && hit_right;

    // ------------------------------------------------------------
    // Queues
    // ------------------------------------------------------------
    // Flip-flop storage costs area but needs no memory macro
    // Inbound filled from the CODEC side, drained by channel reads
    afp_fifo u_left_in (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush_inbound),
        .push(tick_now),
        .push_data(adc_left_in),
        .pop(rd_left),
        .head_data(lin_head),
        .count(left_in_count),
        .full(),
        .empty()
    );

    afp_fifo u_right_in (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush_inbound),
        .push(tick_now),
        .push_data(adc_right_in),
        .pop(rd_right),
        .head_data(rin_head),
        .count(right_in_count),
        .full(),
        .empty()
    );

    // Outbound filled by channel writes; full queue drops the word
    afp_fifo u_left_out (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush_outbound),
        .push(wr_left),
        .push_data(pwdata),
        .pop(tick_now),
        .head_data(lout_head),
        .count(lout_cnt),
        .full(),
        .empty(lout_empty)
    );

    afp_fifo u_right_out (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush_outbound),
        .push(wr_right),
        .push_data(pwdata),
        .pop(tick_now),
        .head_data(rout_head),
        .count(rout_cnt),
        .full(),
        .empty(rout_empty)
    );

    // ------------------------------------------------------------
    // Level register and thresholds
    // ------------------------------------------------------------
    assign left_out_space = free_words(lout_cnt);
    assign right_out_space = free_words(rout_cnt);

    // Empty queues read 0 held and 128 free
    assign level_word = {left_out_space, right_out_space,
                         left_in_count, right_in_count};

    assign in_hot = (left_in_count >= AFP_HIGH_MARK) ||
                    (right_in_count >= AFP_HIGH_MARK);
    assign out_cold = (lout_cnt < AFP_LOW_MARK) ||
                      (rout_cnt < AFP_LOW_MARK);
    assign out_warm = (lout_cnt > AFP_LOW_MARK) &&
                      (rout_cnt > AFP_LOW_MARK);

    // Empty input reads return a stale head word, not an error
    assign read_mux = hit_ctrl ? ctrl_word(ctrl_q, in_pend_q, out_pend_q) :
                      hit_level ? level_word :
                      hit_left ? lin_head :
                      hit_right ? rin_head : 32'h00000000;

    // ------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------
    // Read data is sampled in the setup cycle so it leaves a flop; the
    // pop happens at the completing edge, after the word was captured.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup && !hit_any;
        end
    end

    // Unmapped reads leave the last word standing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (setup && !pwrite && hit_any)
            prdata_q <= read_mux;
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= AFP_CTRL_RESET;
        // Pending bits are derived, so only the four writable bits are kept
        else if (wr_ctrl)
            ctrl_q <= {pwdata[AFP_FLUSH_OUT_BIT], pwdata[AFP_FLUSH_IN_BIT],
                       pwdata[AFP_OUT_IRQ_EN_BIT],
                       pwdata[AFP_IN_IRQ_EN_BIT]};
    end

    // ------------------------------------------------------------
    // Pending flags and interrupt request
    // ------------------------------------------------------------
    // Pending follows the fill level and its enable bit, so only draining, flushing or clearing the enable clears it
    assign in_pend_d = incoming_irq_enable && in_hot;
    // Set below the low mark and cleared only above it; at the mark itself
    // the flag keeps its value, so one word either way cannot toggle it
    assign out_pend_d = outgoing_irq_enable &&
                        (out_cold || (out_pend_q && !out_warm));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_pend_q <= 1'b0;
            out_pend_q <= 1'b0;
        end
        else
        begin
            in_pend_q <= in_pend_d;
            out_pend_q <= out_pend_d;
        end
    end

    // Request rises with the pending bits, never a cycle ahead of them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= in_pend_d || out_pend_d;
    end

    // ------------------------------------------------------------
    // Sample pacing toward the CODEC
    // ------------------------------------------------------------
    // One tick moves both channels, so left and right never drift apart
    assign tick_now = (tick_cnt_q == AFP_TICK_LAST);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_now ? '0 : tick_cnt_q + 12'h001;
            tick_q <= tick_now;
        end
    end

    // Limitation: words leave in parallel; no serial framing is made here
    // Empty outbound queue sends silence rather than repeating a sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_left_q <= '0;
            dac_right_q <= '0;
        end
        else if (tick_now)
        begin
            dac_left_q <= lout_empty ? '0 : lout_head;
            dac_right_q <= rout_empty ? '0 : rout_head;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output leaves a flop, so no decode glitch reaches the pins
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dac_left = dac_left_q;
    assign dac_right = dac_right_q;
    assign sample_tick = tick_q;
    assign irq = irq_q;

endmodule // afp_top

/* tb_afp_top.sv */
// Testbench: register, queue, flush and pacing checks for afp_top
`timescale 1ns/1ps
module tb_afp_top;
    import afp_pkg::*;
    // ------
    // Signals and instances
    // ------
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, adc_l, adc_r, dac_l, dac_r, rd;
    logic [31:0] seed = 32'hc9c3;
    logic pready, pslverr, sample_tick, irq, err;
    logic [31:0] ql[$];
    logic [31:0] qr[$];
    int fails = 0;
    int n_checks = 0;
    time t_last = 0;
    always #25 pclk = ~pclk;
    afp_top afp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_left_in(adc_l), .adc_right_in(adc_r), .dac_left(dac_l),
        .dac_right(dac_r), .sample_tick(sample_tick), .irq(irq));
    afp_codec afp_codec_i (.pclk(pclk), .presetn(presetn),
        .sample_tick(sample_tick), .adc_left_in(adc_l),
        .adc_right_in(adc_r));
    // ------
    // Helpers
    // ------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [31:0] lvl(input logic [7:0] ri, li, rs, ls);
        return {ls, rs, li, ri};
    endfunction
    task automatic chk(input logic [31:0] seen, exp, input string m);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %0t %s: %h not %h", $time, m, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic sync();
        do
            @(posedge pclk);
        while (sample_tick !== 1'h1);
        if (t_last != 0)
            chk(32'($time - t_last), 32'h1e848, "period");
        t_last = $time;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------
    // Sequence
    // ------
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, AFP_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'h1, AFP_LEVEL_ADDR, xs(seed));
        apb(1'h0, AFP_LEVEL_ADDR, 32'h0);
        chk(rd, lvl(8'h0, 8'h0, 8'h80, 8'h80), "level");
        apb(1'h0, 32'hff203050, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        apb(1'h1, AFP_CTRL_ADDR, 32'h1);
        apb(1'h0, AFP_CTRL_ADDR, 32'h0);
        chk(rd, 32'h1, "in enable");
        $display("registers done");
        sync();
        apb(1'h1, AFP_CTRL_ADDR, 32'h2);
        apb(1'h0, AFP_CTRL_ADDR, 32'h0);
        chk(rd, 32'h202, "out pend");
        chk({31'h0, irq}, 32'h1, "irq");
        for (int i = 0; i < 129; i++)
        begin
            seed = xs(seed);
            apb(1'h1, AFP_LEFT_ADDR, seed);
            apb(1'h1, AFP_RIGHT_ADDR, ~seed);
            if (i < 128)
            begin
                ql.push_back(seed);
                qr.push_back(~seed);
            end
            if (i >= 30 && i <= 32)
            begin
                apb(1'h0, AFP_CTRL_ADDR, 32'h0);
                chk(rd, i == 32 ? 32'h2 : 32'h202, "pend edge");
            end
        end
        apb(1'h0, AFP_LEVEL_ADDR, 32'h0);
        chk(rd, lvl(8'h1, 8'h1, 8'h0, 8'h0), "full");
        chk({31'h0, irq}, 32'h0, "irq off");
        for (int k = 0; k < 3; k++)
        begin
            sync();
            chk(dac_l, ql.pop_front(), "dac left");
            chk(dac_r, qr.pop_front(), "dac right");
        end
        $display("outbound done");
        sync();
        apb(1'h0, AFP_LEFT_ADDR, 32'h0);
        chk(rd, 32'h0a0a0000, "left pop");
        apb(1'h0, AFP_RIGHT_ADDR, 32'h0);
        chk(rd, 32'h0b0b0000, "right pop");
        apb(1'h0, AFP_LEFT_ADDR, 32'h0);
        chk(rd, 32'h0a0a0001, "left next");
        apb(1'h0, AFP_LEVEL_ADDR, 32'h0);
        chk(rd, lvl(8'h4, 8'h3, 8'h4, 8'h4), "counts");
        apb(1'h1, AFP_CTRL_ADDR, 32'hc);
        apb(1'h0, AFP_LEFT_ADDR, 32'h0);
        apb(1'h0, AFP_LEVEL_ADDR, 32'h0);
        chk(rd, lvl(8'h0, 8'h0, 8'h80, 8'h80), "flushed");
        sync();
        apb(1'h0, AFP_LEVEL_ADDR, 32'h0);
        chk(rd, lvl(8'h0, 8'h0, 8'h80, 8'h80), "flush held");
        apb(1'h1, AFP_CTRL_ADDR, 32'h0);
        sync();
        apb(1'h0, AFP_LEVEL_ADDR, 32'h0);
        chk(rd, lvl(8'h1, 8'h1, 8'h80, 8'h80), "flush off");
        apb(1'h0, AFP_LEFT_ADDR, 32'h0);
        chk(rd, 32'h0a0a0006, "fresh word");
        $display("inbound done");
        wrap_up();
    end
    initial
    begin
        repeat (40000) @(posedge pclk);
        fails++;
        wrap_up();
    end
endmodule // tb_afp_top
